// *** include/bridge_ctl_pkg.sv ***
// constants for the half-bridge pop-free and fault control block
package bridge_ctl_pkg;
  localparam int NUM_OUT = 3;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // register indices (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PHASE_T = 4'h1;
  localparam logic [ADDR_W-1:0] REG_INT_HOLD_T = 4'h2;
  localparam logic [ADDR_W-1:0] REG_EXT_HOLD_T = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h7;
  // control register fields
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_HIZ_LSB = 1;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_INT_SD = 7;
  localparam int CTRL_EXT_SD = 8;
  localparam int CTRL_DIG_INT = 9;
  localparam int CTRL_DIG_EXT = 10;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h001;
  // time registers are 16-bit (one register each), unit = one tick
  localparam int TIME_W = 16;
  localparam logic [TIME_W-1:0] PHASE_T_RST = 16'h0100;
  localparam logic [TIME_W-1:0] HOLD_T_RST = 16'h0100;
  // tick period 1 us at 200 MHz
  localparam int TICK_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICK_W = 8;
  // status / irq bits
  localparam int IRQ_W = 4;
  localparam int EV_INT_FAULT = 0;
  localparam int EV_EXT_FAULT = 1;
  localparam int EV_UP_DONE = 2;
  localparam int EV_DOWN_DONE = 3;
  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_CHARGE_UP, SEQ_ON, SEQ_CHARGE_DOWN
  } seq_state_t;
endpackage : bridge_ctl_pkg

// *** verilog/bridge_precharge_resistor_ctl_fault_control.sv ***
// half-bridge pop-free sequencing and short-circuit fault control
// Summary of operation
// - per bridge: on when pd=1,ts=1; resistors when pd=1,ts=0,pf=1.
// - lines come from standby bit, per-output hi-z and precharge bits.
// - start-up and switch-off charging sequence runs on its own.
// - charging phase duration comes from the phase time register.
// - each bridge reports short circuit on an active-low fault line.
// - enabled external fault drives hi-z out low, bridges to high impedance.
// - after external fault clears, hold hi-z for external hold time.
// - enabled internal fault puts bridge outputs in high impedance.
// - after internal fault clears, hold hi-z for internal hold time.
// - switch controls avoid high and low side conducting together.
// - digital precharge enabled separately for internal and external stage.
`timescale 1ns/1ps
module bridge_precharge_resistor_ctl_fault_control #(
  parameter int NUM_OUT = bridge_ctl_pkg::NUM_OUT,
  parameter int TICK_CYC = bridge_ctl_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [bridge_ctl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [bridge_ctl_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [bridge_ctl_pkg::DATA_W-1:0] rdata_o,
  // bridge stages
  input wire logic [NUM_OUT-1:0] modulator_channel_in_i,
  input wire logic [NUM_OUT-1:0] bridge_fault_n_i,
  output logic [NUM_OUT-1:0] bridge_powerdown_o,
  output logic [NUM_OUT-1:0] bridge_hiz_n_o,
  output logic [NUM_OUT-1:0] precharge_resistor_ctl_o,
  output logic [NUM_OUT-1:0] high_side_on_o,
  output logic [NUM_OUT-1:0] low_side_on_o,
  // external amplifier
  input wire logic ext_amp_fault_in_n_i,
  output logic ext_amp_hiz_out_n_o,
  // digital ramp precharge enables
  output logic dig_precharge_int_o,
  output logic dig_precharge_ext_o,
  // interrupt
  output logic irq_o
);
  localparam int TW = bridge_ctl_pkg::TIME_W;
  localparam int IW = bridge_ctl_pkg::IRQ_W;
  localparam int CW = bridge_ctl_pkg::CTRL_W;

  logic [CW-1:0] ctrl_r;
  logic [TW-1:0] phase_t_r;
  logic [TW-1:0] int_hold_t_r;
  logic [TW-1:0] ext_hold_t_r;
  logic [IW-1:0] status_r;
  logic [IW-1:0] irq_en_r;
  logic [bridge_ctl_pkg::TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  bridge_ctl_pkg::seq_state_t seq_r;
  logic [TW-1:0] seq_cnt_r;
  logic int_fault_r;
  logic int_fault_d_r;
  logic ext_fault_r;
  logic ext_fault_d_r;
  logic int_hold_r;
  logic ext_hold_r;
  logic [TW-1:0] int_cnt_r;
  logic [TW-1:0] ext_cnt_r;
  logic [IW-1:0] ev;
  logic standby;
  logic [NUM_OUT-1:0] hiz_bits;
  logic [NUM_OUT-1:0] pre_bits;
  logic int_sd;
  logic ext_sd;
  logic force_hiz;
  logic [NUM_OUT-1:0] pd_nxt;
  logic [NUM_OUT-1:0] ts_nxt;
  logic [NUM_OUT-1:0] pf_nxt;

  assign standby = ctrl_r[bridge_ctl_pkg::CTRL_STANDBY];
  assign hiz_bits = ctrl_r[bridge_ctl_pkg::CTRL_HIZ_LSB +: NUM_OUT];
  assign pre_bits = ctrl_r[bridge_ctl_pkg::CTRL_PRE_LSB +: NUM_OUT];
  // internal shutdown when enabled
  // delayed fault covers the cycle before the hold timer loads
  assign int_sd = ctrl_r[bridge_ctl_pkg::CTRL_INT_SD] &
                  (int_fault_r | int_fault_d_r | int_hold_r);
  assign ext_sd = ctrl_r[bridge_ctl_pkg::CTRL_EXT_SD] &
                  (ext_fault_r | ext_fault_d_r | ext_hold_r);
  assign force_hiz = int_sd | ext_sd;

  // tick divider
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == bridge_ctl_pkg::TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= bridge_ctl_pkg::CTRL_RST;
      phase_t_r <= bridge_ctl_pkg::PHASE_T_RST;
      int_hold_t_r <= bridge_ctl_pkg::HOLD_T_RST;
      ext_hold_t_r <= bridge_ctl_pkg::HOLD_T_RST;
      irq_en_r <= '0;
    end else if (wr_i) begin
      unique case (addr_i)
        bridge_ctl_pkg::REG_CTRL: ctrl_r <= wdata_i[CW-1:0];
        bridge_ctl_pkg::REG_PHASE_T: phase_t_r <= wdata_i[TW-1:0];
        bridge_ctl_pkg::REG_INT_HOLD_T: int_hold_t_r <= wdata_i[TW-1:0];
        bridge_ctl_pkg::REG_EXT_HOLD_T: ext_hold_t_r <= wdata_i[TW-1:0];
        bridge_ctl_pkg::REG_IRQ_EN: irq_en_r <= wdata_i[IW-1:0];
        default: ;
      endcase
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        bridge_ctl_pkg::REG_CTRL: rdata_o <= 32'(ctrl_r);
        bridge_ctl_pkg::REG_PHASE_T: rdata_o <= 32'(phase_t_r);
        bridge_ctl_pkg::REG_INT_HOLD_T: rdata_o <= 32'(int_hold_t_r);
        bridge_ctl_pkg::REG_EXT_HOLD_T: rdata_o <= 32'(ext_hold_t_r);
        bridge_ctl_pkg::REG_STATUS: rdata_o <= 32'(status_r);
        bridge_ctl_pkg::REG_IRQ_EN: rdata_o <= 32'(irq_en_r);
        bridge_ctl_pkg::REG_STATE: rdata_o <= {24'h000000, ext_hold_r,
          int_hold_r, ext_fault_r, int_fault_r, 1'b0, 3'(seq_r)};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_fault_r <= 1'b0;
      ext_fault_r <= 1'b0;
      int_fault_d_r <= 1'b0;
      ext_fault_d_r <= 1'b0;
    end else begin
      int_fault_r <= ~&bridge_fault_n_i;
      ext_fault_r <= ~ext_amp_fault_in_n_i;
      int_fault_d_r <= int_fault_r;
      ext_fault_d_r <= ext_fault_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_hold_r <= 1'b0;
      int_cnt_r <= '0;
    end else if (int_fault_r) begin
      int_hold_r <= 1'b0;
      int_cnt_r <= '0;
    end else if (int_fault_d_r) begin
      int_hold_r <= int_hold_t_r != '0;
      int_cnt_r <= int_hold_t_r;
    end else if (int_hold_r && tick_r) begin
      int_cnt_r <= int_cnt_r - 1'b1;
      int_hold_r <= int_cnt_r != TW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_hold_r <= 1'b0;
      ext_cnt_r <= '0;
    end else if (ext_fault_r) begin
      ext_hold_r <= 1'b0;
      ext_cnt_r <= '0;
    end else if (ext_fault_d_r) begin
      ext_hold_r <= ext_hold_t_r != '0;
      ext_cnt_r <= ext_hold_t_r;
    end else if (ext_hold_r && tick_r) begin
      ext_cnt_r <= ext_cnt_r - 1'b1;
      ext_hold_r <= ext_cnt_r != TW'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_r <= bridge_ctl_pkg::SEQ_OFF;
      seq_cnt_r <= '0;
    end else begin
      unique case (seq_r)
        bridge_ctl_pkg::SEQ_OFF: begin
          if (!standby) begin
            seq_r <= bridge_ctl_pkg::SEQ_CHARGE_UP;
            seq_cnt_r <= phase_t_r;
          end
        end
        bridge_ctl_pkg::SEQ_CHARGE_UP: begin
          if (standby) begin
            seq_r <= bridge_ctl_pkg::SEQ_OFF;
          end else if (seq_cnt_r == '0) begin
            seq_r <= bridge_ctl_pkg::SEQ_ON;
          end else if (tick_r) begin
            seq_cnt_r <= seq_cnt_r - 1'b1;
          end
        end
        bridge_ctl_pkg::SEQ_ON: begin
          if (standby) begin
            seq_r <= bridge_ctl_pkg::SEQ_CHARGE_DOWN;
            seq_cnt_r <= phase_t_r;
          end
        end
        bridge_ctl_pkg::SEQ_CHARGE_DOWN: begin
          if (seq_cnt_r == '0) begin
            seq_r <= bridge_ctl_pkg::SEQ_OFF;
          end else if (tick_r) begin
            seq_cnt_r <= seq_cnt_r - 1'b1;
          end
        end
        default: seq_r <= bridge_ctl_pkg::SEQ_OFF;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      pd_nxt[i] = seq_r != bridge_ctl_pkg::SEQ_OFF;
      ts_nxt[i] = (seq_r == bridge_ctl_pkg::SEQ_ON) && hiz_bits[i] &&
                  !force_hiz;
      pf_nxt[i] = pre_bits[i] &&
                  (seq_r == bridge_ctl_pkg::SEQ_CHARGE_UP ||
                   seq_r == bridge_ctl_pkg::SEQ_CHARGE_DOWN);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bridge_powerdown_o <= '0;
      bridge_hiz_n_o <= '0;
      precharge_resistor_ctl_o <= '0;
    end else begin
      bridge_powerdown_o <= pd_nxt;
      bridge_hiz_n_o <= ts_nxt;
      precharge_resistor_ctl_o <= pf_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      high_side_on_o <= '0;
      low_side_on_o <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        high_side_on_o[i] <= ts_nxt[i] && pd_nxt[i] &&
          modulator_channel_in_i[i] && !low_side_on_o[i];
        low_side_on_o[i] <= ts_nxt[i] && pd_nxt[i] &&
          !modulator_channel_in_i[i] && !high_side_on_o[i];
      end
    end
  end

  // external amplifier hi-z and precharge enables
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_amp_hiz_out_n_o <= 1'b0;
      dig_precharge_int_o <= 1'b0;
      dig_precharge_ext_o <= 1'b0;
    end else begin
      ext_amp_hiz_out_n_o <= !ext_sd;
      dig_precharge_int_o <= ctrl_r[bridge_ctl_pkg::CTRL_DIG_INT];
      dig_precharge_ext_o <= ctrl_r[bridge_ctl_pkg::CTRL_DIG_EXT];
    end
  end

  // sticky status, set wins over clear
  assign ev[bridge_ctl_pkg::EV_INT_FAULT] = int_fault_r & ~int_fault_d_r;
  assign ev[bridge_ctl_pkg::EV_EXT_FAULT] = ext_fault_r & ~ext_fault_d_r;
  assign ev[bridge_ctl_pkg::EV_UP_DONE] =
    (seq_r == bridge_ctl_pkg::SEQ_CHARGE_UP) && !standby && seq_cnt_r == '0;
  assign ev[bridge_ctl_pkg::EV_DOWN_DONE] =
    (seq_r == bridge_ctl_pkg::SEQ_CHARGE_DOWN) && seq_cnt_r == '0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r &
        ~((wr_i && addr_i == bridge_ctl_pkg::REG_IRQ_CLR) ?
          wdata_i[IW-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_r & irq_en_r);
    end
  end

  // assertions
  // powered-on bridge never has resistors connected
  property p_on_no_res;
    @(posedge clk_i) disable iff (rst_i)
      bridge_hiz_n_o != '0 |->
        (bridge_hiz_n_o & precharge_resistor_ctl_o) == '0;
  endproperty
  a_on_no_res: assert property (p_on_no_res)
    else $error("bridge on with resistors connected");

  // internal fault forces hi-z within two cycles
  property p_int_hiz;
    @(posedge clk_i) disable iff (rst_i)
      (!(&bridge_fault_n_i) && ctrl_r[bridge_ctl_pkg::CTRL_INT_SD])
        ##1 ctrl_r[bridge_ctl_pkg::CTRL_INT_SD] |=> bridge_hiz_n_o == '0;
  endproperty
  a_int_hiz: assert property (p_int_hiz)
    else $error("bridge not hi-z during internal fault");

  // external fault drives hi-z out low
  property p_ext_hiz;
    @(posedge clk_i) disable iff (rst_i)
      (!ext_amp_fault_in_n_i && ctrl_r[bridge_ctl_pkg::CTRL_EXT_SD])
        ##1 ctrl_r[bridge_ctl_pkg::CTRL_EXT_SD] |=> !ext_amp_hiz_out_n_o;
  endproperty
  a_ext_hiz: assert property (p_ext_hiz)
    else $error("external hi-z not asserted on fault");

  property p_no_shoot;
    @(posedge clk_i) disable iff (rst_i)
      (high_side_on_o & low_side_on_o) == '0;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("high and low side on together");

  // hold starts after external fault clears
  property p_ext_hold;
    @(posedge clk_i) disable iff (rst_i)
      $fell(ext_fault_r) && ext_hold_t_r != '0 |=> ext_hold_r;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("external hold not started");

  // hold starts after internal fault clears
  property p_int_hold;
    @(posedge clk_i) disable iff (rst_i)
      $fell(int_fault_r) && int_hold_t_r != '0 |=> int_hold_r;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("internal hold not started");

  property p_refault;
    @(posedge clk_i) disable iff (rst_i)
      int_fault_r |=> !int_hold_r;
  endproperty
  a_refault: assert property (p_refault)
    else $error("hold running during fault");

  // charge-up with count at zero and standby clear moves to on
  property p_seq;
    @(posedge clk_i) disable iff (rst_i)
      seq_r == bridge_ctl_pkg::SEQ_CHARGE_UP && !standby && seq_cnt_r == '0
        |=> seq_r == bridge_ctl_pkg::SEQ_ON;
  endproperty
  a_seq: assert property (p_seq)
    else $error("start-up sequence did not complete");
endmodule : bridge_precharge_resistor_ctl_fault_control

// *** tb/bridge_stage_model.sv ***
// behavioural model of the three analog half-bridge stages and amp pin
`timescale 1ns/1ps
module bridge_stage_model (
  // control lines from the core
  input wire logic [2:0] pd_i,
  input wire logic [2:0] ts_i,
  input wire logic [2:0] pf_i,
  // commanded shorts
  input wire logic [2:0] short_i,
  input wire logic ext_short_i,
  // feedback and observed stage status
  output logic [2:0] fault_n_o,
  output logic ext_fault_n_o,
  output logic [2:0] on_o,
  output logic [2:0] res_o
);
  assign on_o = pd_i & ts_i;
  assign res_o = pd_i & ~ts_i & pf_i;
  assign fault_n_o = ~short_i;
  assign ext_fault_n_o = ~ext_short_i;
endmodule : bridge_stage_model

// *** tb/test_bridge_precharge_resistor_ctl_fault_control.sv ***
// self-checking bench for the bridge pop-free and fault control block
`timescale 1ns/1ps
module test_bridge_precharge_resistor_ctl_fault_control;
  localparam int SEQ_CYC = 4;
  localparam int HOLD_CYC = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [2:0] mod_i = 3'h0;
  logic [2:0] short = 3'h0;
  logic ext_short = 1'b0;
  logic [2:0] fault_n, pd, hiz_n, pf, hs, ls, on, res;
  logic ext_fault_n, ext_hiz_n, dig_int, dig_ext, irq;
  logic [31:0] d;
  int n;
  int cycles = 0;
  int errors = 0;
  int checks_done = 0;

  bridge_precharge_resistor_ctl_fault_control #(.TICK_CYC(2)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .modulator_channel_in_i(mod_i), .bridge_fault_n_i(fault_n),
    .bridge_powerdown_o(pd), .bridge_hiz_n_o(hiz_n),
    .precharge_resistor_ctl_o(pf), .high_side_on_o(hs),
    .low_side_on_o(ls), .ext_amp_fault_in_n_i(ext_fault_n),
    .ext_amp_hiz_out_n_o(ext_hiz_n), .dig_precharge_int_o(dig_int),
    .dig_precharge_ext_o(dig_ext), .irq_o(irq));
  bridge_stage_model i_model (.pd_i(pd), .ts_i(hiz_n), .pf_i(pf),
    .short_i(short), .ext_short_i(ext_short), .fault_n_o(fault_n),
    .ext_fault_n_o(ext_fault_n), .on_o(on), .res_o(res));

  always #2.5 clk_i = ~clk_i;
  // modulator never in binary headphone mode here
  always @(posedge clk_i) mod_i <= mod_i + 3'h1;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  always @(negedge clk_i) begin
    if (!rst_i) chk({29'h0, hs & ls}, 32'h0, "both sides");
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp,
      input string msg);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp, msg);
  endtask : rchk

  task automatic set_flt(input logic [2:0] s, input logic e);
    @(posedge clk_i);
    short <= s;
    ext_short <= e;
  endtask : set_flt

  // wait for powerdown (sel=1) or three-state lines (sel=0) to reach exp
  task automatic wait3(input bit sel, input logic [2:0] exp, input int max);
    n = 0;
    while (((sel ? pd : hiz_n) !== exp) && n < max) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk({29'h0, sel ? pd : hiz_n}, {29'h0, exp}, "wait level");
  endtask : wait3

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk({29'h0, pd}, 32'h0, "pd standby");
    chk({29'h0, hiz_n}, 32'h0, "ts standby");
    chk({31'h0, ext_hiz_n}, 32'h1, "ext idle");
    rchk(bridge_ctl_pkg::REG_CTRL, 32'h001, "ctrl rst");
    rchk(bridge_ctl_pkg::REG_PHASE_T, 32'h100, "phase rst");
    rchk(bridge_ctl_pkg::REG_INT_HOLD_T, 32'h100, "ihold rst");
    rchk(bridge_ctl_pkg::REG_EXT_HOLD_T, 32'h100, "ehold rst");
    rchk(4'h8, 32'h0, "unmapped");
    $display("test reset done");
    wr(bridge_ctl_pkg::REG_PHASE_T, 32'h2);
    wr(bridge_ctl_pkg::REG_INT_HOLD_T, 32'h2);
    wr(bridge_ctl_pkg::REG_EXT_HOLD_T, 32'h2);
    // ramp and resistor precharge never enabled together
    wr(bridge_ctl_pkg::REG_CTRL, 32'h201);
    @(posedge clk_i);
    #1;
    chk({30'h0, dig_ext, dig_int}, 32'h1, "dig int");
    wr(bridge_ctl_pkg::REG_CTRL, 32'h1BA);
    wait3(1'b1, 3'h7, 10);
    chk({29'h0, hiz_n}, 32'h0, "charge ts");
    chk({29'h0, res}, 32'h3, "resistors");
    chk({30'h0, dig_ext, dig_int}, 32'h0, "dig en");
    wait3(1'b0, 3'h5, 40);
    chk(32'(n >= SEQ_CYC - 1), 32'h1, "phase len");
    chk({29'h0, on}, 32'h5, "bridges on");
    chk({29'h0, (hs | ls) & ~on}, 32'h0, "sw gated");
    rchk(bridge_ctl_pkg::REG_STATUS, 32'h4, "up done");
    rd(bridge_ctl_pkg::REG_STATE, d);
    chk(d & 32'h7, 32'(bridge_ctl_pkg::SEQ_ON), "seq on");
    $display("test startup done");
    wr(bridge_ctl_pkg::REG_IRQ_CLR, 32'hF);
    wr(bridge_ctl_pkg::REG_IRQ_EN, 32'h1);
    set_flt(3'h1, 1'b0);
    wait3(1'b0, 3'h0, 5);
    @(posedge clk_i);
    #1;
    chk({31'h0, irq}, 32'h1, "irq set");
    rchk(bridge_ctl_pkg::REG_STATUS, 32'h1, "int status");
    set_flt(3'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    set_flt(3'h1, 1'b0);
    repeat (3) @(posedge clk_i);
    #1;
    chk({29'h0, hiz_n}, 32'h0, "refault");
    set_flt(3'h0, 1'b0);
    wait3(1'b0, 3'h5, 30);
    chk(32'(n >= HOLD_CYC), 32'h1, "hold restart");
    wr(bridge_ctl_pkg::REG_IRQ_CLR, 32'h1);
    rchk(bridge_ctl_pkg::REG_STATUS, 32'h0, "cleared");
    chk({31'h0, irq}, 32'h0, "irq clr");
    rchk(bridge_ctl_pkg::REG_IRQ_CLR, 32'h0, "clr reads 0");
    wr(bridge_ctl_pkg::REG_IRQ_EN, 32'h0);
    set_flt(3'h4, 1'b0);
    wait3(1'b0, 3'h0, 5);
    chk({31'h0, irq}, 32'h0, "irq mask");
    set_flt(3'h0, 1'b0);
    wait3(1'b0, 3'h5, 30);
    chk(32'(n >= HOLD_CYC), 32'h1, "int hold");
    $display("test internal fault done");
    set_flt(3'h0, 1'b1);
    wait3(1'b0, 3'h0, 5);
    chk({31'h0, ext_hiz_n}, 32'h0, "ext out");
    set_flt(3'h0, 1'b0);
    wait3(1'b0, 3'h5, 30);
    chk(32'(n >= HOLD_CYC), 32'h1, "ext hold");
    chk({31'h0, ext_hiz_n}, 32'h1, "ext back");
    wr(bridge_ctl_pkg::REG_CTRL, 32'h40A);
    wr(bridge_ctl_pkg::REG_IRQ_CLR, 32'hF);
    set_flt(3'h1, 1'b1);
    repeat (5) @(posedge clk_i);
    #1;
    chk({29'h0, hiz_n}, 32'h5, "no sd");
    chk({31'h0, ext_hiz_n}, 32'h1, "no ext sd");
    chk({30'h0, dig_ext, dig_int}, 32'h2, "dig ext");
    rchk(bridge_ctl_pkg::REG_STATUS, 32'h3, "events");
    set_flt(3'h0, 1'b0);
    repeat (20) @(posedge clk_i);
    $display("test external fault done");
    wr(bridge_ctl_pkg::REG_IRQ_CLR, 32'hF);
    wr(bridge_ctl_pkg::REG_CTRL, 32'h03B);
    wait3(1'b0, 3'h0, 10);
    chk({29'h0, pd}, 32'h7, "down pd");
    chk({29'h0, res}, 32'h3, "down res");
    wait3(1'b1, 3'h0, 40);
    chk(32'(n >= SEQ_CYC - 1), 32'h1, "down len");
    rchk(bridge_ctl_pkg::REG_STATUS, 32'h8, "down done");
    wr(bridge_ctl_pkg::REG_STATUS, 32'h0);
    rchk(bridge_ctl_pkg::REG_STATUS, 32'h8, "status ro");
    $display("test switch-off done");
    stop_test();
  end
endmodule : test_bridge_precharge_resistor_ctl_fault_control
